// ===== common/rcsm_pkg.sv
// Constants and types for the receive control, statistics and memory bank
package rcsm_pkg;
	// ==============================================
	// Register offsets (byte offsets on the register port)
	localparam logic [3:0]  ADDR_RX_CTRL  = 4'h4;
	localparam logic [3:0]  ADDR_TX_EVT   = 4'h6;
	localparam logic [3:0]  ADDR_MEM_INFO = 4'h8;
	localparam logic [3:0]  ADDR_MEM_CFG  = 4'hA;

	// ==============================================
	// Receive control field positions
	localparam int          RC_SOFT_RST   = 15;
	localparam int          RC_CAR_FILT   = 14;
	localparam int          RC_CRC_RM     = 9;
	localparam int          RC_RX_ON      = 8;
	localparam int          RC_ALL_MCAST  = 2;
	localparam int          RC_PROMISC    = 1;
	localparam int          RC_ABORT      = 0;
	localparam logic [15:0] RC_RESET      = 16'h0000;

	// ==============================================
	// Event counter field positions (low bit of each nibble)
	localparam int          EC_SNGL_COL   = 0;
	localparam int          EC_MULT_COL   = 4;
	localparam int          EC_DEFER      = 8;
	localparam int          EC_EXC_DEFER  = 12;
	localparam logic [3:0]  EC_MAX        = 4'hF;

	// ==============================================
	// Memory information and configuration
	localparam logic [7:0]  MEM_TOTAL     = 8'h18;
	localparam logic [7:0]  MCR_UPPER     = 8'h33;
	localparam logic [2:0]  MCR_MULT_ONE  = 3'h1;
	localparam int          MCR_MULT_LSB  = 9;
	localparam logic [7:0]  MCR_RESV_RST  = 8'h00;

	// ==============================================
	// Timing
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          BIT_TIME_NS   = 100;
	localparam int          CRS_FILT_BITS = 12;
	localparam int          CRS_FILT_CYC  =
		(CRS_FILT_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] MAX_FRAME     = 11'h5FC;
	localparam logic [4:0]  COL_MAX       = 5'h10;

	// ==============================================
	// Receive frame states
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_RECV = 2'b01,
		S_DROP = 2'b11
	} rcsm_rx_state_type;
endpackage

// ===== hw/rcsm_crs_filter.sv
// Carrier sense leading edge filter
`timescale 1ns/1ps
module rcsm_crs_filter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Carrier and control
	input  wire logic crs,
	input  wire logic filt_en,
	// Qualified carrier
	output logic      crs_valid
);
	localparam logic [4:0] LAST = 5'(rcsm_pkg::CRS_FILT_CYC - 1);

	logic [4:0] cnt_r;

	// ==============================================
	// Hold-off counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_r <= 5'h00;
		else if (!crs || crs_valid)
			cnt_r <= 5'h00;
		else
			cnt_r <= cnt_r + 5'h01;
	end

	// A short carrier glitch never opens a frame when filtering is on
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			crs_valid <= 1'b0;
		else if (!crs)
			crs_valid <= 1'b0;
		else if (!filt_en || cnt_r == LAST)
			crs_valid <= 1'b1;
	end

	property p_filt_hold;
		@(posedge clk) disable iff (!nrst)
		$rose(crs_valid) && filt_en |-> $past(cnt_r) == LAST;
	endproperty
	a_filt_hold: assert property (p_filt_hold)
		else $error("carrier qualified before hold-off");

	property p_filt_off;
		@(posedge clk) disable iff (!nrst)
		crs && !filt_en |=> crs_valid;
	endproperty
	a_filt_off: assert property (p_filt_off)
		else $error("carrier not taken at once with filter off");
endmodule

// ===== hw/rcsm_evt_counter.sv
// Saturating per-packet event counter, cleared on read
`timescale 1ns/1ps
module rcsm_evt_counter (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Controls
	input  wire logic       clr,
	input  wire logic       pkt_done,
	input  wire logic       evt,
	// Count
	output logic [3:0]      count
);
	// ==============================================
	// Counter: an increment in the clearing cycle is kept as one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			count <= 4'h0;
		else if (pkt_done && evt) begin
			if (clr)
				count <= 4'h1;
			else if (count != rcsm_pkg::EC_MAX)
				count <= count + 4'h1;
		end else if (clr)
			count <= 4'h0;
	end

	property p_no_wrap;
		@(posedge clk) disable iff (!nrst)
		count == rcsm_pkg::EC_MAX && !clr |=> count == rcsm_pkg::EC_MAX;
	endproperty
	a_no_wrap: assert property (p_no_wrap)
		else $error("event counter wrapped");

	property p_one_step;
		@(posedge clk) disable iff (!nrst)
		!clr |=> count == $past(count) || count == $past(count) + 4'h1;
	endproperty
	a_one_step: assert property (p_one_step)
		else $error("event counter stepped by more than one");
endmodule

// ===== hw/rcsm_regs.sv
// Receive control, transmit statistics and memory registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module rcsm_regs (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// Receive side
	input  wire logic        crs,
	input  wire logic        rx_byte,
	input  wire logic        rx_da_mcast,
	input  wire logic        rx_mcast_hit,
	input  wire logic        rx_addr_hit,
	input  wire logic        rx_src_self,
	input  wire logic        full_duplex_mode,
	output logic             rx_active,
	output logic             rx_store,
	output logic             rx_discard,
	output logic             crc_removal,
	// Transmit statistics
	input  wire logic        tx_collision,
	input  wire logic        tx_defer,
	input  wire logic        tx_exc_defer,
	input  wire logic        tx_pkt_done,
	output logic             counter_rollover_flag,
	output logic             counter_irq,
	// Memory allocation
	input  wire logic        mmu_reset,
	input  wire logic        alloc_req,
	input  wire logic        alloc_rx,
	input  wire logic        page_release,
	output logic             alloc_grant,
	output logic             alloc_deny,
	// Chip-wide soft reset level
	output logic             soft_reset
);
	logic [15:0]                 rc_r;
	logic [7:0]                  resv_r;
	logic [7:0]                  free_r;
	logic [4:0]                  col_cnt_r;
	logic                        defer_seen_r;
	logic                        exc_seen_r;
	logic [3:0]                  cnt_sngl;
	logic [3:0]                  cnt_mult;
	logic [3:0]                  cnt_defer;
	logic [3:0]                  cnt_exc;
	logic                        ec_clr;
	logic                        evt_sngl;
	logic                        evt_mult;
	logic                        evt_defer;
	logic                        evt_exc;
	logic                        crs_valid;
	logic                        abort_set;
	logic                        frame_ok;
	logic                        rx_deny;
	logic [10:0]                 byte_cnt_r;
	rcsm_pkg::rcsm_rx_state_type state_r;
	rcsm_pkg::rcsm_rx_state_type state_nxt;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// ==============================================
	// Receive control register
	assign soft_reset  = rc_r[rcsm_pkg::RC_SOFT_RST];
	assign crc_removal = rc_r[rcsm_pkg::RC_CRC_RM];
	assign ec_clr      = rd && hit(addr, rcsm_pkg::ADDR_TX_EVT);

	// Writable bits only; the abort flag is hardware set, software cleared
	// Station address, base and configuration registers live outside this
	// bank, so a soft reset cannot disturb them, and nothing here asks for
	// a setup reload from the serial memory.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rc_r <= rcsm_pkg::RC_RESET;
		else begin
			if (wr && hit(addr, rcsm_pkg::ADDR_RX_CTRL)) begin
				if (wdata[rcsm_pkg::RC_SOFT_RST])
					rc_r <= rcsm_pkg::RC_RESET | 16'h8000;
				else begin
					rc_r[rcsm_pkg::RC_SOFT_RST]  <= 1'b0;
					rc_r[rcsm_pkg::RC_CAR_FILT]  <= wdata[rcsm_pkg::RC_CAR_FILT];
					rc_r[rcsm_pkg::RC_CRC_RM]    <= wdata[rcsm_pkg::RC_CRC_RM];
					rc_r[rcsm_pkg::RC_RX_ON]     <= wdata[rcsm_pkg::RC_RX_ON];
					rc_r[rcsm_pkg::RC_ALL_MCAST] <= wdata[rcsm_pkg::RC_ALL_MCAST];
					rc_r[rcsm_pkg::RC_PROMISC]   <= wdata[rcsm_pkg::RC_PROMISC];
					rc_r[rcsm_pkg::RC_ABORT] <= rc_r[rcsm_pkg::RC_ABORT] &&
						wdata[rcsm_pkg::RC_ABORT];
				end
			end
			if (abort_set && !soft_reset)
				rc_r[rcsm_pkg::RC_ABORT] <= 1'b1;
		end
	end

	// ==============================================
	// Carrier qualification
	rcsm_crs_filter u_filt (
		.clk       (clk),
		.nrst      (nrst),
		.crs       (crs),
		.filt_en   (rc_r[rcsm_pkg::RC_CAR_FILT]),
		.crs_valid (crs_valid)
	);

	// ==============================================
	// Receive frame tracking
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rcsm_pkg::S_IDLE:
				if (crs_valid && rc_r[rcsm_pkg::RC_RX_ON] && !soft_reset)
					state_nxt = rcsm_pkg::S_RECV;
			rcsm_pkg::S_RECV:
				if (!crs_valid)
					state_nxt = rcsm_pkg::S_IDLE;
				else if (abort_set)
					state_nxt = rcsm_pkg::S_DROP;
			rcsm_pkg::S_DROP:
				if (!crs_valid)
					state_nxt = rcsm_pkg::S_IDLE;
			default:
				state_nxt = rcsm_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			state_r <= rcsm_pkg::S_IDLE;
		else
			state_r <= state_nxt;
	end

	assign abort_set = state_r == rcsm_pkg::S_RECV && rx_byte &&
		byte_cnt_r == rcsm_pkg::MAX_FRAME;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			byte_cnt_r <= 11'h000;
		else if (state_r != rcsm_pkg::S_RECV)
			byte_cnt_r <= 11'h000;
		else if (rx_byte && byte_cnt_r != rcsm_pkg::MAX_FRAME)
			byte_cnt_r <= byte_cnt_r + 11'h001;
	end

	// Address filter; own frames are rejected outside full duplex mode, even when promiscuous
	always_comb begin
		if (rc_r[rcsm_pkg::RC_PROMISC])
			frame_ok = 1'b1;
		else if (rx_da_mcast)
			frame_ok = rc_r[rcsm_pkg::RC_ALL_MCAST] || rx_mcast_hit;
		else
			frame_ok = rx_addr_hit;
		if (rx_src_self && !full_duplex_mode)
			frame_ok = 1'b0;
	end

	assign rx_active = state_r == rcsm_pkg::S_RECV;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_store   <= 1'b0;
			rx_discard <= 1'b0;
		end else begin
			rx_store   <= rx_active && !crs_valid && frame_ok;
			rx_discard <= abort_set || (rx_active && !crs_valid && !frame_ok);
		end
	end

	// ==============================================
	// Transmit event capture, one packet at a time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			col_cnt_r    <= 5'h00;
			defer_seen_r <= 1'b0;
			exc_seen_r   <= 1'b0;
		end else if (tx_pkt_done || soft_reset) begin
			col_cnt_r    <= 5'h00;
			defer_seen_r <= 1'b0;
			exc_seen_r   <= 1'b0;
		end else begin
			if (tx_collision && col_cnt_r != rcsm_pkg::COL_MAX)
				col_cnt_r <= col_cnt_r + 5'h01;
			if (tx_defer)
				defer_seen_r <= 1'b1;
			if (tx_exc_defer)
				exc_seen_r <= 1'b1;
		end
	end

	// Events landing in the done cycle still belong to that packet
	assign evt_sngl  = col_cnt_r + {4'h0, tx_collision} == 5'h01;
	assign evt_mult  = col_cnt_r + {4'h0, tx_collision} >= 5'h02;
	assign evt_defer = defer_seen_r || tx_defer;
	assign evt_exc   = exc_seen_r || tx_exc_defer;

	rcsm_evt_counter u_sngl (
		.clk      (clk),
		.nrst     (nrst),
		.clr      (ec_clr || soft_reset),
		.pkt_done (tx_pkt_done),
		.evt      (evt_sngl),
		.count    (cnt_sngl)
	);
	rcsm_evt_counter u_mult (
		.clk      (clk),
		.nrst     (nrst),
		.clr      (ec_clr || soft_reset),
		.pkt_done (tx_pkt_done),
		.evt      (evt_mult),
		.count    (cnt_mult)
	);
	rcsm_evt_counter u_defer (
		.clk      (clk),
		.nrst     (nrst),
		.clr      (ec_clr || soft_reset),
		.pkt_done (tx_pkt_done),
		.evt      (evt_defer),
		.count    (cnt_defer)
	);
	rcsm_evt_counter u_exc (
		.clk      (clk),
		.nrst     (nrst),
		.clr      (ec_clr || soft_reset),
		.pkt_done (tx_pkt_done),
		.evt      (evt_exc),
		.count    (cnt_exc)
	);

	function automatic logic to_full(input logic e, input logic [3:0] c);
		to_full = e && c == rcsm_pkg::EC_MAX - 4'h1;
	endfunction

	// Only a counter that really steps to full sets the flag; a read in
	// that cycle restarts the counter at one, so it never reaches full then
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			counter_rollover_flag <= 1'b0;
		else if (ec_clr || soft_reset)
			counter_rollover_flag <= 1'b0;
		else if (tx_pkt_done && (to_full(evt_sngl, cnt_sngl) ||
			to_full(evt_mult, cnt_mult) || to_full(evt_defer, cnt_defer) ||
			to_full(evt_exc, cnt_exc)))
			counter_rollover_flag <= 1'b1;
	end
	assign counter_irq = counter_rollover_flag;

	// ==============================================
	// Memory reservation and free page count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			resv_r <= rcsm_pkg::MCR_RESV_RST;
		else if (soft_reset)
			resv_r <= rcsm_pkg::MCR_RESV_RST;
		else if (wr && hit(addr, rcsm_pkg::ADDR_MEM_CFG))
			resv_r <= wdata[7:0];
	end

	// Zero reservation leaves the sharing fully dynamic
	assign rx_deny = alloc_rx && resv_r != 8'h00 && free_r <= resv_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alloc_grant <= 1'b0;
			alloc_deny  <= 1'b0;
		end else begin
			alloc_grant <= alloc_req && !mmu_reset && free_r != 8'h00 && !rx_deny;
			alloc_deny  <= alloc_req && (mmu_reset || free_r == 8'h00 || rx_deny);
		end
	end

	// Release and grant together leave the count unchanged
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			free_r <= rcsm_pkg::MEM_TOTAL;
		else if (mmu_reset)
			free_r <= rcsm_pkg::MEM_TOTAL;
		else if (alloc_req && free_r != 8'h00 && !rx_deny) begin
			if (!page_release)
				free_r <= free_r - 8'h01;
		end else if (page_release && free_r != rcsm_pkg::MEM_TOTAL)
			free_r <= free_r + 8'h01;
	end

	// ==============================================
	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata <= 16'h0000;
		else if (!rd)
			rdata <= 16'h0000;
		else if (hit(addr, rcsm_pkg::ADDR_RX_CTRL))
			rdata <= rc_r;
		else if (hit(addr, rcsm_pkg::ADDR_TX_EVT))
			rdata <= {cnt_exc, cnt_defer, cnt_mult, cnt_sngl};
		else if (hit(addr, rcsm_pkg::ADDR_MEM_INFO))
			rdata <= {free_r, rcsm_pkg::MEM_TOTAL};
		else if (hit(addr, rcsm_pkg::ADDR_MEM_CFG))
			rdata <= {rcsm_pkg::MCR_UPPER, resv_r};
		else
			rdata <= 16'h0000;
	end

	// ==============================================
	// Checks
	property p_soft_hold;
		@(posedge clk) disable iff (!nrst)
		soft_reset && !(wr && hit(addr, rcsm_pkg::ADDR_RX_CTRL)) |=> soft_reset;
	endproperty
	a_soft_hold: assert property (p_soft_hold)
		else $error("soft reset released without write");

	property p_soft_dflt;
		@(posedge clk) disable iff (!nrst)
		soft_reset && !(wr && hit(addr, rcsm_pkg::ADDR_RX_CTRL))
			|=> resv_r == 8'h00 && !rc_r[rcsm_pkg::RC_RX_ON];
	endproperty
	a_soft_dflt: assert property (p_soft_dflt)
		else $error("configuration not defaulted in soft reset");

	property p_rx_off;
		@(posedge clk) disable iff (!nrst)
		state_r == rcsm_pkg::S_IDLE && !rc_r[rcsm_pkg::RC_RX_ON]
			|=> state_r == rcsm_pkg::S_IDLE;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("frame started with receiver off");

	property p_abort;
		@(posedge clk) disable iff (!nrst)
		abort_set && !soft_reset |=> rc_r[rcsm_pkg::RC_ABORT] &&
			state_r == rcsm_pkg::S_DROP ##1 !rx_store [*2];
	endproperty
	a_abort: assert property (p_abort)
		else $error("oversize frame not aborted");

	property p_abort_clr;
		@(posedge clk) disable iff (!nrst)
		wr && hit(addr, rcsm_pkg::ADDR_RX_CTRL) &&
			!wdata[rcsm_pkg::RC_ABORT] && !abort_set
			|=> !rc_r[rcsm_pkg::RC_ABORT];
	endproperty
	a_abort_clr: assert property (p_abort_clr)
		else $error("abort flag not cleared by write");

	property p_own;
		@(posedge clk) disable iff (!nrst)
		rx_active && !crs_valid && rx_src_self && !full_duplex_mode
			|=> !rx_store;
	endproperty
	a_own: assert property (p_own)
		else $error("own frame stored without full duplex");

	property p_ec_clr;
		@(posedge clk) disable iff (!nrst)
		ec_clr && !tx_pkt_done |=> {cnt_exc, cnt_defer, cnt_mult, cnt_sngl}
			== 16'h0000 && !counter_rollover_flag;
	endproperty
	a_ec_clr: assert property (p_ec_clr)
		else $error("counters not cleared by read");

	property p_roll;
		@(posedge clk) disable iff (!nrst)
		$rose(cnt_sngl == 4'hF || cnt_mult == 4'hF) |-> counter_irq;
	endproperty
	a_roll: assert property (p_roll)
		else $error("rollover flag missing at full count");

	property p_deny;
		@(posedge clk) disable iff (!nrst)
		alloc_req && alloc_rx && resv_r != 8'h00 && free_r <= resv_r
			|=> alloc_deny && !alloc_grant;
	endproperty
	a_deny: assert property (p_deny)
		else $error("receive allocation into reservation");

	property p_mmu_rst;
		@(posedge clk) disable iff (!nrst)
		mmu_reset && !soft_reset && !(wr && hit(addr, rcsm_pkg::ADDR_MEM_CFG))
			|=> free_r == rcsm_pkg::MEM_TOTAL && resv_r == $past(resv_r);
	endproperty
	a_mmu_rst: assert property (p_mmu_rst)
		else $error("free count wrong after memory unit reset");

	property p_mcr_ro;
		@(posedge clk) disable iff (!nrst)
		rd && hit(addr, rcsm_pkg::ADDR_MEM_CFG) |=> rdata[11:9] == 3'h1;
	endproperty
	a_mcr_ro: assert property (p_mcr_ro)
		else $error("multiplier field wrong");

	property p_mem_total;
		@(posedge clk) disable iff (!nrst)
		rd && hit(addr, rcsm_pkg::ADDR_MEM_INFO)
			|=> rdata[7:0] == rcsm_pkg::MEM_TOTAL;
	endproperty
	a_mem_total: assert property (p_mem_total)
		else $error("total memory size wrong");

	c_store: cover property (@(posedge clk) disable iff (!nrst) rx_store);
	c_abort: cover property (@(posedge clk) disable iff (!nrst) abort_set);
	c_roll:  cover property (@(posedge clk) disable iff (!nrst) counter_irq);
	c_deny:  cover property (@(posedge clk) disable iff (!nrst) alloc_deny);
endmodule

// ===== testbench/rcsm_regs_tb_top.sv
// Self-checking bench for the receive control, statistics and memory bank
`timescale 1ns/1ps
module rcsm_regs_tb_top;
	// ==============================================
	// Signals
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0, rd = 1'b0;
	logic [15:0] rdata;
	logic        crs = 1'b0, rx_byte = 1'b0;
	logic        rx_da_mcast = 1'b0, rx_mcast_hit = 1'b0;
	logic        rx_addr_hit = 1'b0, rx_src_self = 1'b0;
	logic        full_duplex_mode = 1'b0;
	logic        tx_collision = 1'b0, tx_defer = 1'b0;
	logic        tx_exc_defer = 1'b0, tx_pkt_done = 1'b0;
	logic        mmu_reset = 1'b0, alloc_req = 1'b0;
	logic        alloc_rx = 1'b0, page_release = 1'b0;
	logic        rx_active, rx_store, rx_discard, crc_removal;
	logic        counter_rollover_flag, counter_irq;
	logic        alloc_grant, alloc_deny, soft_reset;
	logic [15:0] v;
	logic        b;
	int          num_errors = 0;
	int          tests_run = 0;
	int          n_st = 0, n_dc = 0;

	// ==============================================
	// Device under test
	rcsm_regs u_rcsm_regs (
		.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata),
		.crs(crs), .rx_byte(rx_byte), .rx_da_mcast(rx_da_mcast),
		.rx_mcast_hit(rx_mcast_hit), .rx_addr_hit(rx_addr_hit),
		.rx_src_self(rx_src_self), .full_duplex_mode(full_duplex_mode),
		.rx_active(rx_active), .rx_store(rx_store),
		.rx_discard(rx_discard), .crc_removal(crc_removal),
		.tx_collision(tx_collision), .tx_defer(tx_defer),
		.tx_exc_defer(tx_exc_defer), .tx_pkt_done(tx_pkt_done),
		.counter_rollover_flag(counter_rollover_flag),
		.counter_irq(counter_irq), .mmu_reset(mmu_reset),
		.alloc_req(alloc_req), .alloc_rx(alloc_rx),
		.page_release(page_release), .alloc_grant(alloc_grant),
		.alloc_deny(alloc_deny), .soft_reset(soft_reset)
	);

	// ==============================================
	// Clock and frame result monitor
	initial begin
		forever #25 clk = ~clk;
	end

	// Pulses are one cycle wide, so counting them per edge sees each once
	always @(posedge clk) begin
		if (rx_store === 1'b1) n_st++;
		if (rx_discard === 1'b1) n_dc++;
	end

	// ==============================================
	// Access tasks
	task chk(input string name, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wr_reg(input logic [3:0] a, input logic [15:0] dt);
		@(posedge clk);
		addr <= a;
		wdata <= dt;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task rchk(input string n, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, rdata, e);
	endtask

	task pkt(input int nc, input int nd, input int ne);
		repeat (nc) begin
			@(posedge clk) tx_collision <= 1'b1;
			@(posedge clk) tx_collision <= 1'b0;
		end
		repeat (nd) begin
			@(posedge clk) tx_defer <= 1'b1;
			@(posedge clk) tx_defer <= 1'b0;
		end
		repeat (ne) begin
			@(posedge clk) tx_exc_defer <= 1'b1;
			@(posedge clk) tx_exc_defer <= 1'b0;
		end
		@(posedge clk) tx_pkt_done <= 1'b1;
		@(posedge clk) tx_pkt_done <= 1'b0;
		#1;
	endtask

	task frame(input int nb, input logic mc, mh, ah, sf, input bit off);
		n_st = 0;
		n_dc = 0;
		@(posedge clk);
		crs <= 1'b1;
		rx_da_mcast <= mc;
		rx_mcast_hit <= mh;
		rx_addr_hit <= ah;
		rx_src_self <= sf;
		repeat (30) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			if (off && i == 4) wr_reg(4'h4, 16'h0000);
			@(posedge clk) rx_byte <= 1'b1;
			@(posedge clk) rx_byte <= 1'b0;
		end
		@(posedge clk) crs <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	task car(input int n, output logic a);
		@(posedge clk) crs <= 1'b1;
		repeat (n) @(posedge clk);
		#1;
		a = rx_active;
		@(posedge clk) crs <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	task alloc(input logic r);
		@(posedge clk);
		alloc_req <= 1'b1;
		alloc_rx <= r;
		@(posedge clk);
		alloc_req <= 1'b0;
		#1;
		v = {14'h0000, alloc_grant, alloc_deny};
	endtask

	task end_of_test;
		$display("Checks run %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==============================================
	// Watchdog: the sequence needs well under 12000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		end_of_test;
	end

	// ==============================================
	// Test sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rchk("rx_ctrl", 4'h4, 16'h0000);
		rchk("tx_evt", 4'h6, 16'h0000);
		rchk("mem_info", 4'h8, 16'h1818);
		rchk("mem_cfg", 4'hA, 16'h3300);
		rchk("unmapped", 4'h0, 16'h0000);
		wr_reg(4'hA, 16'hFFFF);
		rchk("mem_cfg", 4'hA, 16'h33FF);
		wr_reg(4'h8, 16'h0000);
		rchk("mem_info", 4'h8, 16'h1818);
		pkt(1, 0, 0);
		wr_reg(4'h4, 16'hFFFF);
		chk("soft_reset", {15'h0000, soft_reset}, 16'h0001);
		rchk("rx_ctrl", 4'h4, 16'h8000);
		rchk("tx_evt", 4'h6, 16'h0000);
		rchk("mem_cfg", 4'hA, 16'h3300);
		wr_reg(4'h4, 16'h7FFF);
		chk("soft_reset", {15'h0000, soft_reset}, 16'h0000);
		rchk("rx_ctrl", 4'h4, 16'h4306);
		rchk("mem_info", 4'h8, 16'h1818);

		// Several events inside one packet still count once
		pkt(1, 2, 1);
		pkt(2, 0, 0);
		pkt(16, 0, 0);
		rchk("tx_evt", 4'h6, 16'h1121);
		rchk("tx_evt", 4'h6, 16'h0000);
		repeat (14) pkt(1, 0, 0);
		chk("rollover", {15'h0000, counter_rollover_flag}, 16'h0000);
		pkt(1, 0, 0);
		chk("rollover", {15'h0000, counter_rollover_flag}, 16'h0001);
		chk("irq", {15'h0000, counter_irq}, 16'h0001);
		pkt(1, 1, 0);
		rchk("tx_evt", 4'h6, 16'h010F);
		chk("rollover", {15'h0000, counter_rollover_flag}, 16'h0000);

		wr_reg(4'h4, 16'h0100);
		chk("crc_rm", {15'h0000, crc_removal}, 16'h0000);
		car(2, b);
		chk("car_off", {15'h0000, b}, 16'h0001);
		wr_reg(4'h4, 16'h4100);
		car(rcsm_pkg::CRS_FILT_CYC - 4, b);
		chk("car_early", {15'h0000, b}, 16'h0000);
		car(rcsm_pkg::CRS_FILT_CYC + 4, b);
		chk("car_late", {15'h0000, b}, 16'h0001);
		wr_reg(4'h4, 16'h0300);
		chk("crc_rm", {15'h0000, crc_removal}, 16'h0001);
		frame(8, 0, 0, 1, 0, 0);
		chk("store", n_st[15:0], 16'h0001);
		frame(8, 1, 0, 0, 0, 0);
		chk("store", n_st[15:0], 16'h0000);
		frame(8, 1, 1, 0, 0, 0);
		chk("store", n_st[15:0], 16'h0001);
		wr_reg(4'h4, 16'h0104);
		frame(8, 1, 0, 0, 0, 0);
		chk("store", n_st[15:0], 16'h0001);
		wr_reg(4'h4, 16'h0102);
		frame(8, 0, 0, 0, 0, 0);
		chk("store", n_st[15:0], 16'h0001);
		frame(8, 0, 0, 0, 1, 0);
		chk("store", n_st[15:0], 16'h0000);
		@(posedge clk) full_duplex_mode <= 1'b1;
		frame(8, 0, 0, 0, 1, 0);
		chk("store", n_st[15:0], 16'h0001);
		@(posedge clk) full_duplex_mode <= 1'b0;
		wr_reg(4'h4, 16'h0100);
		frame(8, 0, 0, 1, 0, 1);
		chk("store", n_st[15:0], 16'h0001);
		frame(8, 0, 0, 1, 0, 0);
		chk("store", {n_st[7:0], n_dc[7:0]}, 16'h0000);
		wr_reg(4'h4, 16'h0100);
		frame(1532, 0, 0, 1, 0, 0);
		chk("store", {n_st[7:0], n_dc[7:0]}, 16'h0100);
		frame(1533, 0, 0, 1, 0, 0);
		chk("store", {n_st[7:0], n_dc[7:0]}, 16'h0001);
		rchk("rx_ctrl", 4'h4, 16'h0101);
		wr_reg(4'h4, 16'h0100);
		rchk("rx_ctrl", 4'h4, 16'h0100);

		wr_reg(4'hA, 16'h0017);
		alloc(1'b1);
		chk("alloc", v, 16'h0002);
		rchk("mem_info", 4'h8, 16'h1718);
		alloc(1'b1);
		chk("alloc", v, 16'h0001);
		alloc(1'b0);
		chk("alloc", v, 16'h0002);
		wr_reg(4'hA, 16'h0016);
		alloc(1'b1);
		chk("alloc", v, 16'h0001);
		wr_reg(4'hA, 16'h0000);
		alloc(1'b1);
		chk("alloc", v, 16'h0002);
		rchk("mem_info", 4'h8, 16'h1518);
		wr_reg(4'hA, 16'h0003);
		@(posedge clk) mmu_reset <= 1'b1;
		@(posedge clk) mmu_reset <= 1'b0;
		rchk("mem_info", 4'h8, 16'h1818);
		rchk("mem_cfg", 4'hA, 16'h3303);
		@(posedge clk) page_release <= 1'b1;
		@(posedge clk) page_release <= 1'b0;
		rchk("mem_info", 4'h8, 16'h1818);

		// A second hardware reset in mid-run
		@(posedge clk) nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rchk("mem_cfg", 4'hA, 16'h3300);
		rchk("rx_ctrl", 4'h4, 16'h0000);
		end_of_test;
	end
endmodule
